// >>> hdl/pmsl_level_dec.sv
`timescale 1ns/1ps
module pmsl_level_dec
	import pmsl_pkg::*;
(
	input wire logic [7:0] i_security_byte,
	output pmsl_level_t o_level
);

	wire table_read_lock_bit;
	wire verify_lock_bit;
	wire external_exec_lock_bit;

	// Zero in a lock bit turns that protection on.
	assign table_read_lock_bit =
		(i_security_byte[SEC_BIT_TBL] == SEC_PROGRAMMED);
	assign verify_lock_bit =
		(i_security_byte[SEC_BIT_VER] == SEC_PROGRAMMED);
	assign external_exec_lock_bit =
		(i_security_byte[SEC_BIT_EXT] == SEC_PROGRAMMED);

	// Only cumulative patterns are legal; any other pattern is taken as
	// the strongest level, because failing closed leaks nothing.
	always_comb begin
		case ({external_exec_lock_bit, verify_lock_bit,
			table_read_lock_bit})
			3'h0: o_level = LVL_OPEN;
			3'h1: o_level = LVL_TBL;
			3'h3: o_level = LVL_VER;
			3'h7: o_level = LVL_FULL;
			default: o_level = LVL_FULL;
		endcase
	end

endmodule

// >>> hdl/pmsl_pkg.sv
package pmsl_pkg;

	// Bit positions of the three lock bits inside the security byte.
	localparam int SEC_BIT_TBL = 0;
	localparam int SEC_BIT_VER = 1;
	localparam int SEC_BIT_EXT = 3;

	// A lock bit reads zero when it is programmed.
	localparam logic SEC_PROGRAMMED = 1'b0;

	// Cycles after reset release before the synchronised byte is trusted.
	localparam logic [1:0] SETTLE_CYC = 2'h3;
	localparam logic [1:0] SETTLE_STEP = 2'h1;

	// Signature index limit and the idle data value.
	localparam logic [1:0] SIG_LAST_IDX = 2'h2;
	localparam logic [7:0] DATA_IDLE = 8'h00;

	// Cumulative protection levels, in increasing strength.
	typedef enum logic [1:0] {
		LVL_OPEN,
		LVL_TBL,
		LVL_VER,
		LVL_FULL
	} pmsl_level_t;

	// Processor requests, all one-cycle pulses in the core clock domain.
	typedef struct packed {
		logic ext_fetch;
		logic tbl_rd;
		logic tbl_from_ext;
		logic ram_acc;
	} pmsl_cpu_req_t;

	// Registered answers to the processor.
	typedef struct packed {
		logic ext_fetch_ok;
		logic tbl_rd_ok;
		logic ram_ok;
		logic fault;
	} pmsl_cpu_gnt_t;

	// Programmer request levels as they arrive on the pins.
	typedef struct packed {
		logic prog;
		logic verify;
		logic sig;
		logic [1:0] sig_idx;
	} pmsl_prg_req_t;

	// Registered answers to the programmer.
	typedef struct packed {
		logic ack;
		logic refused;
		logic prog_we;
		logic [7:0] data;
	} pmsl_prg_rsp_t;

endpackage

// >>> hdl/pmsl_top.sv
// Overview of operation
// - All bits unprogrammed: verify allowed, no restrictions.
// - Lock bit one blocks external table reads.
// - Lock bit one rejects further programming.
// - Bits one and two also disable verify.
// - All three bits block external code execution.
// - All three bits make data RAM inaccessible.
// - Three signature bytes readable by programmer.
// - Security byte bits, zero enables protection.
`timescale 1ns/1ps
module pmsl_top
	import pmsl_pkg::*;
#(
	parameter logic [7:0] SIG_BYTE_0 = 8'hA5, // Arbitrary value.
	parameter logic [7:0] SIG_BYTE_1 = 8'h5A, // Arbitrary value.
	parameter logic [7:0] SIG_BYTE_2 = 8'h3C  // Arbitrary value.
)
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_security_byte,
	input wire pmsl_cpu_req_t i_cpu_req,
	input wire pmsl_prg_req_t i_prg_req,
	input wire logic [7:0] i_code_rdata,
	output pmsl_cpu_gnt_t o_cpu_gnt,
	output pmsl_prg_rsp_t o_prg_rsp,
	output pmsl_level_t o_level,
	output logic o_level_valid
);

	logic [7:0] sec_s1_ff;
	logic [7:0] sec_s2_ff;
	pmsl_prg_req_t prg_s1_ff;
	pmsl_prg_req_t prg_s2_ff;
	pmsl_prg_req_t prg_prev_ff;
	logic [1:0] settle_ff;
	pmsl_level_t lvl_ff;
	logic lvl_valid_ff;
	pmsl_cpu_gnt_t gnt_ff;
	pmsl_prg_rsp_t rsp_ff;
	pmsl_level_t dec_lvl;
	pmsl_cpu_gnt_t nxt_gnt;
	pmsl_prg_rsp_t nxt_rsp;
	logic [1:0] nxt_settle;

	wire rise_prog;
	wire rise_verify;
	wire rise_sig;
	wire tbl_lock;
	wire prog_lock;
	wire ver_lock;
	wire full_lock;
	wire sig_bad;
	wire take_prog;
	wire take_verify;
	wire take_sig;
	wire [7:0] sig_data;
	wire settle_done;

	// Both pin groups come from outside the core clock domain.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sec_s1_ff <= '1;
			sec_s2_ff <= '1;
			prg_s1_ff <= '0;
			prg_s2_ff <= '0;
			prg_prev_ff <= '0;
		end else begin
			sec_s1_ff <= i_security_byte;
			sec_s2_ff <= sec_s1_ff;
			prg_s1_ff <= i_prg_req;
			prg_s2_ff <= prg_s1_ff;
			prg_prev_ff <= prg_s2_ff;
		end
	end

	pmsl_level_dec u_dec (
		.i_security_byte(sec_s2_ff),
		.o_level(dec_lvl)
	);

	// The byte is only trusted once the synchroniser has refilled.
	assign settle_done = (settle_ff == SETTLE_CYC);
	assign nxt_settle = settle_done ? settle_ff : settle_ff + SETTLE_STEP;

	// The level is caught once after release and then frozen; until then
	// it sits at the strongest level so nothing escapes early.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			settle_ff <= '0;
			lvl_ff <= LVL_FULL;
			lvl_valid_ff <= 1'b0;
		end else begin
			settle_ff <= nxt_settle;
			if (settle_done && !lvl_valid_ff) begin
				lvl_ff <= dec_lvl;
				lvl_valid_ff <= 1'b1;
			end
		end
	end

	// Cumulative lock terms; each level includes all weaker ones.
	assign tbl_lock = (lvl_ff != LVL_OPEN);
	assign prog_lock = (lvl_ff != LVL_OPEN);
	assign ver_lock = (lvl_ff == LVL_VER) || (lvl_ff == LVL_FULL);
	assign full_lock = (lvl_ff == LVL_FULL);

	// Processor answers are registered one cycle after the request.
	// Only table reads issued from external code are stopped; internal
	// code may still read its own tables at any level.
	always_comb begin
		nxt_gnt.ext_fetch_ok = i_cpu_req.ext_fetch && !full_lock;
		nxt_gnt.tbl_rd_ok = i_cpu_req.tbl_rd &&
			!(i_cpu_req.tbl_from_ext && tbl_lock);
		nxt_gnt.ram_ok = i_cpu_req.ram_acc && !full_lock;
		nxt_gnt.fault = (i_cpu_req.ext_fetch && full_lock) ||
			(i_cpu_req.tbl_rd && i_cpu_req.tbl_from_ext && tbl_lock) ||
			(i_cpu_req.ram_acc && full_lock);
	end

	// Programmer requests are taken on the rising edge of each level.
	assign rise_prog = prg_s2_ff.prog && !prg_prev_ff.prog;
	assign rise_verify = prg_s2_ff.verify && !prg_prev_ff.verify;
	assign rise_sig = prg_s2_ff.sig && !prg_prev_ff.sig;

	// Programming wins over verify, verify over signature reads.
	assign take_prog = rise_prog;
	assign take_verify = rise_verify && !rise_prog;
	assign take_sig = rise_sig && !rise_verify && !rise_prog;
	assign sig_bad = (prg_s2_ff.sig_idx > SIG_LAST_IDX);

	// Signature bytes are always readable, whatever the level.
	assign sig_data = (prg_s2_ff.sig_idx == 2'h0) ? SIG_BYTE_0 :
		(prg_s2_ff.sig_idx == 2'h1) ? SIG_BYTE_1 :
		(prg_s2_ff.sig_idx == SIG_LAST_IDX) ? SIG_BYTE_2 : DATA_IDLE;

	always_comb begin
		nxt_rsp.ack = take_prog || take_verify || take_sig;
		nxt_rsp.refused = (take_prog && prog_lock) ||
			(take_verify && ver_lock) ||
			(take_sig && sig_bad);
		nxt_rsp.prog_we = take_prog && !prog_lock;
		if (take_verify && !ver_lock) begin
			nxt_rsp.data = i_code_rdata;
		end else if (take_sig) begin
			nxt_rsp.data = sig_data;
		end else begin
			nxt_rsp.data = DATA_IDLE;
		end
	end

	// All answers come straight from flip-flops.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gnt_ff <= '0;
			rsp_ff <= '0;
		end else begin
			gnt_ff <= nxt_gnt;
			rsp_ff <= nxt_rsp;
		end
	end

	assign o_cpu_gnt = gnt_ff;
	assign o_prg_rsp = rsp_ff;
	assign o_level = lvl_ff;
	assign o_level_valid = lvl_valid_ff;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	property p_open_no_restrict;
		(lvl_ff == LVL_OPEN) && lvl_valid_ff && take_verify
			|=> o_prg_rsp.ack && !o_prg_rsp.refused;
	endproperty
	a_open_no_restrict: assert property (p_open_no_restrict)
		else $error("Verify refused with no lock bits programmed.");

	property p_tbl_block;
		i_cpu_req.tbl_rd && i_cpu_req.tbl_from_ext &&
			(lvl_ff != LVL_OPEN) |=> !o_cpu_gnt.tbl_rd_ok && o_cpu_gnt.fault;
	endproperty
	a_tbl_block: assert property (p_tbl_block)
		else $error("External table read reached internal code.");

	property p_prog_block;
		take_prog && (lvl_ff != LVL_OPEN)
			|=> o_prg_rsp.refused && !o_prg_rsp.prog_we;
	endproperty
	a_prog_block: assert property (p_prog_block)
		else $error("Programming accepted while locked.");

	property p_verify_block;
		take_verify && ((lvl_ff == LVL_VER) || (lvl_ff == LVL_FULL))
			|=> o_prg_rsp.refused && (o_prg_rsp.data == DATA_IDLE);
	endproperty
	a_verify_block: assert property (p_verify_block)
		else $error("Code data leaked through verify.");

	property p_ext_exec_block;
		(lvl_ff == LVL_FULL) && i_cpu_req.ext_fetch
			|=> !o_cpu_gnt.ext_fetch_ok && o_cpu_gnt.fault;
	endproperty
	a_ext_exec_block: assert property (p_ext_exec_block)
		else $error("External fetch granted at full protection.");

	property p_ram_block;
		(o_level == LVL_FULL) |-> !o_cpu_gnt.ram_ok;
	endproperty
	a_ram_block: assert property (p_ram_block)
		else $error("Data RAM granted at full protection.");

	property p_sig_read;
		take_sig && (prg_s2_ff.sig_idx == 2'h1)
			|=> o_prg_rsp.ack && (o_prg_rsp.data == SIG_BYTE_1);
	endproperty
	a_sig_read: assert property (p_sig_read)
		else $error("Signature byte one not returned.");

	property p_decode_capture;
		$rose(lvl_valid_ff) |-> (lvl_ff == $past(dec_lvl));
	endproperty
	a_decode_capture: assert property (p_decode_capture)
		else $error("Captured level differs from decoded byte.");

	property p_level_hold;
		lvl_valid_ff |=> lvl_valid_ff && $stable(lvl_ff);
	endproperty
	a_level_hold: assert property (p_level_hold)
		else $error("Protection level changed before reset.");

endmodule

// >>> tb/pmsl_prog_model.sv
`timescale 1ns/1ps
// Programming station: raises one function pin, holds it until the answer,
// then keeps all pins low long enough for the pin synchroniser to see it.
module pmsl_prog_model
	import pmsl_pkg::*;
(
	input wire logic i_mclk,
	input wire pmsl_prg_rsp_t i_rsp,
	output pmsl_prg_req_t o_req
);
	initial o_req = '0;

	// One pin at a time, because simultaneous rises lose all but one.
	task automatic run(input logic [2:0] op, input logic [1:0] idx,
		output pmsl_prg_rsp_t rsp);
		rsp = '0;
		@(negedge i_mclk);
		o_req = {op, idx};
		for (int n = 0; n < 12 && rsp.ack !== 1'b1; n++) begin
			@(posedge i_mclk);
			#1;
			if (i_rsp.ack === 1'b1) rsp = i_rsp;
		end
		@(negedge i_mclk);
		o_req = '0;
		repeat (4) @(negedge i_mclk);
	endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
// Compares a design value with its expectation and counts both.
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module testbench
	import pmsl_pkg::*;
;
	// Arbitrary signature values.
	localparam logic [7:0] SIG [3] = '{8'h6B, 8'h2E, 8'hD1};
	// Lock patterns {ext, verify, table}; the last is not cumulative.
	localparam logic [2:0] PAT [5] = '{3'h7, 3'h6, 3'h4, 3'h0, 3'h5};
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sec_byte = 8'hFF;
	logic [7:0] code_rdata = 8'h00;
	pmsl_cpu_req_t cpu_req = '0;
	pmsl_prg_req_t prg_req;
	pmsl_cpu_gnt_t cpu_gnt;
	pmsl_prg_rsp_t prg_rsp;
	pmsl_level_t level;
	logic level_valid;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;

	pmsl_top #(.SIG_BYTE_0(SIG[0]), .SIG_BYTE_1(SIG[1]),
		.SIG_BYTE_2(SIG[2])) dut (.i_mclk(mclk), .i_rst_n(rst_n),
		.i_security_byte(sec_byte), .i_cpu_req(cpu_req),
		.i_prg_req(prg_req), .i_code_rdata(code_rdata),
		.o_cpu_gnt(cpu_gnt), .o_prg_rsp(prg_rsp), .o_level(level),
		.o_level_valid(level_valid));
	pmsl_prog_model u_prog (.i_mclk(mclk), .i_rsp(prg_rsp),
		.o_req(prg_req));

	// Level expected from the three lock bits; odd patterns act as full.
	function automatic pmsl_level_t exp_lvl(logic [7:0] s);
		case ({s[SEC_BIT_EXT], s[SEC_BIT_VER], s[SEC_BIT_TBL]})
			3'h7: exp_lvl = LVL_OPEN;
			3'h6: exp_lvl = LVL_TBL;
			3'h4: exp_lvl = LVL_VER;
			default: exp_lvl = LVL_FULL;
		endcase
	endfunction

	// Grant expected one cycle after a processor request.
	function automatic pmsl_cpu_gnt_t exp_gnt(pmsl_level_t l,
		pmsl_cpu_req_t r);
		logic full;
		logic blk;
		full = (l == LVL_FULL);
		blk = r.tbl_rd && r.tbl_from_ext && l != LVL_OPEN;
		exp_gnt.ext_fetch_ok = r.ext_fetch && !full;
		exp_gnt.tbl_rd_ok = r.tbl_rd && !blk;
		exp_gnt.ram_ok = r.ram_acc && !full;
		exp_gnt.fault = ((r.ext_fetch || r.ram_acc) && full) || blk;
	endfunction

	// Answer expected for a programming, verify or signature request.
	function automatic pmsl_prg_rsp_t exp_prg(pmsl_level_t l,
		logic [2:0] op, logic [1:0] idx, logic [7:0] cd);
		exp_prg = '0;
		exp_prg.ack = 1'b1;
		if (op[2]) begin
			exp_prg.refused = (l != LVL_OPEN);
			exp_prg.prog_we = (l == LVL_OPEN);
		end else if (op[1]) begin
			exp_prg.refused = (l >= LVL_VER);
			if (l < LVL_VER) exp_prg.data = cd;
		end else if (idx == 2'h3) begin
			exp_prg.refused = 1'b1;
		end else begin
			exp_prg.data = SIG[idx];
		end
	endfunction

	// Drives one request cycle; the caller clears the request afterwards.
	task automatic cpu(pmsl_cpu_req_t r, pmsl_level_t l);
		cpu_req = r;
		@(negedge mclk);
		`CHK(cpu_gnt, exp_gnt(l, r))
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always #10 mclk = ~mclk;

	// Cuts a hang short well beyond the few hundred cycles needed.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			end_of_test();
		end
	end

	initial begin
		pmsl_prg_rsp_t r;
		pmsl_cpu_req_t q;
		logic [7:0] sb;
		pmsl_level_t l;
		logic [2:0] op;
		logic [1:0] ix;
		void'($urandom(32'h67493CF6));
		foreach (PAT[i]) begin
			sb = 8'($urandom());
			{sb[SEC_BIT_EXT], sb[SEC_BIT_VER], sb[SEC_BIT_TBL]} = PAT[i];
			l = exp_lvl(sb);
			@(negedge mclk);
			rst_n = 1'b0;
			sec_byte = sb;
			repeat (6) @(negedge mclk);
			`CHK(level, LVL_FULL)
			rst_n = 1'b1;
			// Before capture a data RAM access must be refused.
			cpu(4'h1, LVL_FULL);
			cpu_req = '0;
			for (int n = 0; n < 8 && level_valid !== 1'b1; n++) begin
				@(negedge mclk);
			end
			`CHK(level_valid, 1'b1)
			`CHK(level, l)
			sec_byte = ~sb;
			cpu(4'hF, l);
			for (int k = 0; k < 6; k++) begin
				q = 4'($urandom());
				q.tbl_from_ext &= q.tbl_rd;
				cpu(q, l);
			end
			cpu_req = '0;
			`CHK(level, l)
			for (int k = 0; k < 6; k++) begin
				op = (k == 0) ? 3'h4 : (k == 1) ? 3'h2 : 3'h1;
				code_rdata = 8'($urandom());
				ix = 2'(k + 2);
				u_prog.run(op, ix, r);
				`CHK(r, exp_prg(l, op, ix, code_rdata))
			end
		end
		end_of_test();
	end
endmodule
